// ==== rtl/ocn_note_logic.v ====
`timescale 1ns/1ps
`default_nettype none
`include "ocn_map.vh"
module ocn_note_logic #(
  parameter NOTES  = 61,
  parameter IW     = 6,
  parameter PNOTES = 32,
  parameter STOPS  = 8,
  parameter PIST   = 8,
  parameter SHOES  = 8,
  parameter NEXP   = 2,
  parameter MS_CYC = `OCN_MS_US * `OCN_CLK_MHZ
) (
  // Clock and reset
  input  wire                 clock,
  input  wire                 reset,
  // Key and contact pins
  input  wire [NOTES-1:0]     key_a,
  input  wire [NOTES-1:0]     key_b,
  input  wire [PNOTES-1:0]    key_p,
  input  wire [STOPS-1:0]     stop_on,
  input  wire [PIST-1:0]      pist_a,
  input  wire [PIST-1:0]      pist_b,
  input  wire [PIST-1:0]      canc_a,
  input  wire [PIST-1:0]      canc_b,
  input  wire [SHOES*4-1:0]   shoe,
  // Stop control pins
  input  wire                 xfer_on,
  input  wire                 unison_off_a,
  input  wire                 unison_off_b,
  input  wire                 cpl_on,
  input  wire                 melody_on,
  input  wire                 bass_on,
  input  wire                 pizz_on,
  input  wire                 sost_on,
  input  wire                 gliss_on,
  input  wire                 intra_on,
  // Configuration
  input  wire                 xfer_cancels,
  input  wire                 cpl_src_sel,
  input  wire [3:0]           cpl_dest,
  input  wire signed [7:0]    cpl_pitch,
  input  wire signed [7:0]    intra_pitch,
  input  wire [NOTES*8-1:0]   pizz_len,
  input  wire                 gliss_two,
  input  wire [7:0]           gliss_rate,
  input  wire                 divide_on,
  input  wire [IW-1:0]        divide_at,
  input  wire [1:0]           pd_low_mode,
  input  wire [1:0]           pd_high_mode,
  input  wire [1:0]           pd_low_sel,
  input  wire [1:0]           pd_high_sel,
  input  wire [STOPS-1:0]     dup_req,
  input  wire [NEXP-1:0]      exp_en,
  input  wire [NEXP*3-1:0]    exp_src,
  input  wire [NEXP*SHOES-1:0] exp_dst,
  // Division note outputs
  output reg  [NOTES-1:0]     div_a_unc_ff,
  output reg  [NOTES-1:0]     div_a_cpl_ff,
  output reg  [NOTES-1:0]     div_b_unc_ff,
  output reg  [NOTES-1:0]     div_b_cpl_ff,
  output reg  [NOTES-1:0]     flt_notes_ff,
  output reg  [3:0]           flt_dest_ff,
  output reg  [NOTES-1:0]     only_on_ff,
  output reg  [NOTES-1:0]     midi_to_ff,
  output reg  [NOTES-1:0]     midi_on_ff,
  output reg  [PNOTES-1:0]    ped_stop_ff,
  output reg  [PNOTES-1:0]    ped_cpl_ff,
  // Pistons, duplex and shades
  output reg  [PIST-1:0]      pist_a_ff,
  output reg  [PIST-1:0]      pist_b_ff,
  output reg  [PIST-1:0]      canc_a_ff,
  output reg  [PIST-1:0]      canc_b_ff,
  output reg                  dup_act_ff,
  output reg  [SHOES*4-1:0]   shade_ff
);

  // --------------------------------------------------------------------------
  // Helper functions
  // --------------------------------------------------------------------------
  // Positive offsets raise pitch; notes pushed past either end are dropped.
  function [NOTES-1:0] f_shift;
    input [NOTES-1:0] v;
    input signed [7:0] off;
    integer i;
    integer j;
    begin
      f_shift = {NOTES{1'b0}};
      for (i = 0; i < NOTES; i = i + 1) begin
        j = i - off;
        if (j >= 0 && j < NOTES) begin
          f_shift[i] = v[j];
        end
      end
    end
  endfunction

  function [IW:0] f_high;
    input [NOTES-1:0] v;
    integer i;
    begin
      f_high = {(IW+1){1'b0}};
      for (i = 0; i < NOTES; i = i + 1) begin
        if (v[i]) begin
          f_high = {1'b1, i[IW-1:0]};
        end
      end
    end
  endfunction

  function [IW:0] f_low;
    input [NOTES-1:0] v;
    integer i;
    begin
      f_low = {(IW+1){1'b0}};
      for (i = NOTES - 1; i >= 0; i = i - 1) begin
        if (v[i]) begin
          f_low = {1'b1, i[IW-1:0]};
        end
      end
    end
  endfunction

  function [NOTES-1:0] f_onehot;
    input          vld;
    input [IW-1:0] idx;
    integer i;
    begin
      for (i = 0; i < NOTES; i = i + 1) begin
        f_onehot[i] = vld && (idx == i[IW-1:0]);
      end
    end
  endfunction

  function signed [7:0] f_clamp;
    input signed [7:0] p;
    begin
      if (p < `OCN_PITCH_MIN) begin
        f_clamp = `OCN_PITCH_MIN;
      end else if (p > `OCN_PITCH_MAX) begin
        f_clamp = `OCN_PITCH_MAX;
      end else begin
        f_clamp = p;
      end
    end
  endfunction

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  localparam SW = 2*NOTES + PNOTES + STOPS + 4*PIST + SHOES*4 + 10;
  wire [SW-1:0] pin_in = {key_a, key_b, key_p, stop_on, pist_a, pist_b,
                          canc_a, canc_b, shoe, xfer_on, unison_off_a,
                          unison_off_b, cpl_on, melody_on, bass_on,
                          pizz_on, sost_on, gliss_on, intra_on};
  reg  [SW-1:0] sync1_ff;
  reg  [SW-1:0] sync2_ff;
  wire [NOTES-1:0]   ka_s;
  wire [NOTES-1:0]   kb_s;
  wire [PNOTES-1:0]  kp_s;
  wire [STOPS-1:0]   stop_s;
  wire [PIST-1:0]    pa_s;
  wire [PIST-1:0]    pb_s;
  wire [PIST-1:0]    ca_s;
  wire [PIST-1:0]    cb_s;
  wire [SHOES*4-1:0] shoe_s;
  wire xfer_s;
  wire uoff_a_s;
  wire uoff_b_s;
  wire cpl_s;
  wire mel_s;
  wire bass_s;
  wire pizz_s;
  wire sost_s;
  wire gl_s;
  wire intra_s;
  assign {ka_s, kb_s, kp_s, stop_s, pa_s, pb_s, ca_s, cb_s, shoe_s, xfer_s,
          uoff_a_s, uoff_b_s, cpl_s, mel_s, bass_s, pizz_s, sost_s, gl_s,
          intra_s} = sync2_ff;

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  reg  [13:0]      ms_cnt_ff;
  reg              tick_ff;
  reg  [4:0]       gl_off_ff;
  reg  [7:0]       gl_ms_ff;
  reg              sost_prev_ff;
  reg  [NOTES-1:0] sost_lat_ff;
  reg              mel_prev_ff;
  reg              mel_v_ff;
  reg  [IW-1:0]    mel_idx_ff;
  reg  [7:0]       deg_ms_ff;
  reg              bass_prev_ff;
  reg              bass_v_ff;
  reg  [IW-1:0]    bass_idx_ff;
  reg  [NOTES-1:0] blk_ff;
  reg  [NOTES-1:0] pz_seen_ff;
  wire [NOTES-1:0] pz_act;

  // --------------------------------------------------------------------------
  // Transfer, glissando, unison and intra coupling
  // --------------------------------------------------------------------------
  wire [NOTES-1:0] ka = xfer_s ? kb_s : ka_s;
  wire [NOTES-1:0] kb = xfer_s ? ka_s : kb_s;
  wire signed [7:0] gl_sh = {3'h0, gl_off_ff};
  wire [NOTES-1:0] ka_g = f_shift(ka, gl_sh);
  wire [NOTES-1:0] kb_g = f_shift(kb, gl_sh);
  wire [NOTES-1:0] kp_w = f_shift({{(NOTES-PNOTES){1'b0}}, kp_s}, gl_sh);
  wire [PNOTES-1:0] kp_g = kp_w[PNOTES-1:0];
  wire keys_any = (|ka_s) | (|kb_s) | (|kp_s);
  wire [4:0] gl_max = gliss_two ? `OCN_GL_TWO : `OCN_GL_ONE;
  wire [NOTES-1:0] a_uni = uoff_a_s ? {NOTES{1'b0}} : ka_g;
  wire [NOTES-1:0] b_uni = uoff_b_s ? {NOTES{1'b0}} : kb_g;
  wire [NOTES-1:0] intra_b =
    intra_s ? f_shift(kb_g, f_clamp(intra_pitch)) : {NOTES{1'b0}};
  wire [NOTES-1:0] b_intra = b_uni | intra_b;

  // --------------------------------------------------------------------------
  // Special coupler attributes
  // --------------------------------------------------------------------------
  wire [NOTES-1:0] src = cpl_src_sel ? b_intra : ka_g;
  wire [IW:0] hi = f_high(src);
  wire [IW:0] lo_all = f_low(src);
  wire [IW:0] lo = f_low(src & ~blk_ff);
  wire mel_move = hi[IW] && (!mel_v_ff || hi[IW-1:0] > mel_idx_ff);
  wire mel_diff = (hi[IW] != mel_v_ff) || (hi[IW-1:0] != mel_idx_ff);
  wire bass_lost = bass_v_ff && !src[bass_idx_ff];
  wire [NOTES-1:0] sel_vec =
    mel_s  ? f_onehot(mel_v_ff, mel_idx_ff) :
    bass_s ? f_onehot(bass_v_ff, bass_idx_ff) : src;
  wire [NOTES-1:0] pz_trig = {NOTES{pizz_s}} & sel_vec & ~pz_seen_ff;
  wire [NOTES-1:0] att_vec =
    (pizz_s ? (pz_act & sel_vec) : sel_vec) | sost_lat_ff;
  wire [NOTES-1:0] cpl_vec =
    cpl_s ? f_shift(att_vec, f_clamp(cpl_pitch)) : {NOTES{1'b0}};

  genvar g;
  generate
    for (g = 0; g < NOTES; g = g + 1) begin : g_pz
      ocn_pizz_timer u_pz (
        .clock  (clock),
        .reset  (reset),
        .trig   (pz_trig[g]),
        .tick   (tick_ff),
        .len    (pizz_len[g*8 +: 8]),
        .act_ff (pz_act[g])
      );
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Pedal divide, duplex and expression
  // --------------------------------------------------------------------------
  reg [PNOTES-1:0]  nxt_ped_stop;
  reg [PNOTES-1:0]  nxt_ped_cpl;
  reg [SHOES*4-1:0] nxt_shade;
  reg [1:0]         pm;
  reg [1:0]         ps;
  integer p;
  integer k;
  integer s;

  always @* begin
    nxt_ped_stop = {PNOTES{1'b0}};
    nxt_ped_cpl  = {PNOTES{1'b0}};
    pm = `OCN_PD_NORMAL;
    ps = 2'h0;
    for (p = 0; p < PNOTES; p = p + 1) begin
      if (!divide_on) begin
        pm = `OCN_PD_NORMAL;
        ps = 2'h0;
      end else if (p < divide_at) begin
        pm = pd_low_mode;
        ps = pd_low_sel;
      end else begin
        pm = pd_high_mode;
        ps = pd_high_sel;
      end
      case (pm)
        `OCN_PD_NORMAL: begin
          nxt_ped_stop[p] = kp_g[p];
          nxt_ped_cpl[p]  = kp_g[p];
        end
        `OCN_PD_STOPS: begin
          nxt_ped_stop[p] = kp_g[p];
        end
        `OCN_PD_COUPLED: begin
          nxt_ped_cpl[p] = kp_g[p];
        end
        default: begin
          nxt_ped_stop[p] = kp_g[p] & ps[0];
          nxt_ped_cpl[p]  = kp_g[p] & ps[1];
        end
      endcase
    end
    nxt_shade = shoe_s;
    for (k = 0; k < NEXP; k = k + 1) begin
      for (s = 0; s < SHOES; s = s + 1) begin
        if (exp_en[k] && exp_dst[k*SHOES + s]) begin
          nxt_shade[s*4 +: 4] = shoe_s[exp_src[k*3 +: 3]*4 +: 4];
        end
      end
    end
  end

  wire dup_two = |(dup_req & (dup_req - {{(STOPS-1){1'b0}}, 1'b1}));
  wire nxt_dup = dup_two && ((stop_s & dup_req) == dup_req);

  // --------------------------------------------------------------------------
  // Sequential logic
  // --------------------------------------------------------------------------
  wire [NOTES-1:0] dest_a = (cpl_dest == `OCN_DEST_A) ? cpl_vec : {NOTES{1'b0}};
  wire [NOTES-1:0] dest_b = (cpl_dest == `OCN_DEST_B) ? cpl_vec : {NOTES{1'b0}};
  wire dest_flt = (cpl_dest != `OCN_DEST_A) && (cpl_dest != `OCN_DEST_B);
  wire xc = xfer_s && xfer_cancels;

  always @(posedge clock) begin
    if (reset) begin
      sync1_ff     <= {SW{1'b0}};
      sync2_ff     <= {SW{1'b0}};
      ms_cnt_ff    <= 14'h0000;
      tick_ff      <= 1'b0;
      gl_off_ff    <= 5'h00;
      gl_ms_ff     <= 8'h00;
      sost_prev_ff <= 1'b0;
      sost_lat_ff  <= {NOTES{1'b0}};
      mel_prev_ff  <= 1'b0;
      mel_v_ff     <= 1'b0;
      mel_idx_ff   <= {IW{1'b0}};
      deg_ms_ff    <= 8'h00;
      bass_prev_ff <= 1'b0;
      bass_v_ff    <= 1'b0;
      bass_idx_ff  <= {IW{1'b0}};
      blk_ff       <= {NOTES{1'b0}};
      pz_seen_ff   <= {NOTES{1'b0}};
      div_a_unc_ff <= {NOTES{1'b0}};
      div_a_cpl_ff <= {NOTES{1'b0}};
      div_b_unc_ff <= {NOTES{1'b0}};
      div_b_cpl_ff <= {NOTES{1'b0}};
      flt_notes_ff <= {NOTES{1'b0}};
      flt_dest_ff  <= 4'h0;
      only_on_ff   <= {NOTES{1'b0}};
      midi_to_ff   <= {NOTES{1'b0}};
      midi_on_ff   <= {NOTES{1'b0}};
      ped_stop_ff  <= {PNOTES{1'b0}};
      ped_cpl_ff   <= {PNOTES{1'b0}};
      pist_a_ff    <= {PIST{1'b0}};
      pist_b_ff    <= {PIST{1'b0}};
      canc_a_ff    <= {PIST{1'b0}};
      canc_b_ff    <= {PIST{1'b0}};
      dup_act_ff   <= 1'b0;
      shade_ff     <= {(SHOES*4){1'b0}};
    end else begin
      sync1_ff <= pin_in;
      sync2_ff <= sync1_ff;
      tick_ff  <= (ms_cnt_ff == MS_CYC - 1);
      if (ms_cnt_ff == MS_CYC - 1) begin
        ms_cnt_ff <= 14'h0000;
      end else begin
        ms_cnt_ff <= ms_cnt_ff + 14'h0001;
      end
      // Raised pitch is kept even if glissando drops, until all keys lift.
      if (!keys_any) begin
        gl_off_ff <= 5'h00;
        gl_ms_ff  <= 8'h00;
      end else if (gl_s && tick_ff && gl_off_ff < gl_max) begin
        if (gl_ms_ff + 8'h01 >= gliss_rate) begin
          gl_ms_ff  <= 8'h00;
          gl_off_ff <= gl_off_ff + 5'h01;
        end else begin
          gl_ms_ff <= gl_ms_ff + 8'h01;
        end
      end
      sost_prev_ff <= sost_s;
      if (!sost_s || gl_s) begin
        sost_lat_ff <= {NOTES{1'b0}};
      end else if (!sost_prev_ff) begin
        sost_lat_ff <= sel_vec;
      end
      mel_prev_ff <= mel_s;
      if (!mel_s) begin
        mel_v_ff  <= 1'b0;
        deg_ms_ff <= 8'h00;
      end else if (!mel_prev_ff || mel_move) begin
        mel_v_ff   <= hi[IW];
        mel_idx_ff <= hi[IW-1:0];
        deg_ms_ff  <= 8'h00;
      end else if (!mel_diff) begin
        deg_ms_ff <= 8'h00;
      end else if (deg_ms_ff >= `OCN_DEG_MS) begin
        mel_v_ff   <= hi[IW];
        mel_idx_ff <= hi[IW-1:0];
        deg_ms_ff  <= 8'h00;
      end else if (tick_ff) begin
        deg_ms_ff <= deg_ms_ff + 8'h01;
      end
      bass_prev_ff <= bass_s;
      if (!bass_s) begin
        bass_v_ff <= 1'b0;
        blk_ff    <= {NOTES{1'b0}};
      end else if (!bass_prev_ff) begin
        bass_v_ff   <= lo_all[IW];
        bass_idx_ff <= lo_all[IW-1:0];
        blk_ff      <= {NOTES{1'b0}};
      end else if (bass_lost) begin
        bass_v_ff <= 1'b0;
        blk_ff    <= src;
      end else begin
        blk_ff <= blk_ff & src;
        if (lo[IW] && (!bass_v_ff || lo[IW-1:0] < bass_idx_ff)) begin
          bass_v_ff   <= 1'b1;
          bass_idx_ff <= lo[IW-1:0];
        end
      end
      pz_seen_ff   <= pizz_s ? sel_vec : {NOTES{1'b0}};
      div_a_unc_ff <= ka_g;
      div_b_unc_ff <= kb_g;
      div_a_cpl_ff <= a_uni | dest_a;
      div_b_cpl_ff <= b_intra | dest_b;
      midi_on_ff   <= b_intra | dest_b;
      midi_to_ff   <= cpl_vec;
      only_on_ff   <= b_intra;
      flt_notes_ff <= dest_flt ? cpl_vec : {NOTES{1'b0}};
      flt_dest_ff  <= cpl_dest;
      ped_stop_ff  <= nxt_ped_stop;
      ped_cpl_ff   <= nxt_ped_cpl;
      pist_a_ff    <= xfer_s ? pb_s : pa_s;
      pist_b_ff    <= xfer_s ? pa_s : pb_s;
      canc_a_ff    <= xc ? cb_s : ca_s;
      canc_b_ff    <= xc ? ca_s : cb_s;
      dup_act_ff   <= nxt_dup;
      shade_ff     <= nxt_shade;
    end
  end

endmodule
`default_nettype wire

// ==== rtl/ocn_map.vh ====
// Summary of operation
// - Melody mode couples only the highest held key; a higher press takes over.
// - Turning melody on outputs the highest held key, pitch shifted, at once.
// - Melody output is deglitched against brief dropout of the top key.
// - Bass mode couples only the lowest held key; a lower press takes over.
// - Turning bass on outputs the lowest held key, pitch shifted, at once.
// - After the bass key is released, other held keys wait for a re-press.
// - Couplers shift by a configurable pitch offset over eleven octaves.
// - Pizzicato turns each new note on for a timed pulse, then off.
// - Enabling pizzicato pulses keys already held; later keys pulse too.
// - Pizzicato pulse length is set per note in milliseconds.
// - Sostenuto latches notes held at its activation; later notes play normally.
// - Unison off is inverted: unison plays unless its control is active.
// - Manual transfer exchanges the key inputs of the two manuals.
// - Transfer also swaps pistons; swapping cancels is a configuration option.
// - Coupler destination is one of at most sixteen divisions, floating allowed.
// - Coupled and uncoupled note data are separate outputs per manual.
// - Only-on coupler sources the intra-manual coupled data only.
// - MIDI to follows its own coupler; MIDI on follows the whole division.
// - Pedal divide splits at a selectable key; each part routes independently.
// - A duplexed control acts only when all of its two or more stops are on.
// - Glissando steps held notes up by half steps over one or two octaves.
// - Glissando pitch holds until all keys release and overrides sostenuto.
// - Expression couplers route a chosen shoe to a chosen set of shades.
`ifndef OCN_MAP_VH
`define OCN_MAP_VH

// --------------------------------------------------------------------------
// Timing
// --------------------------------------------------------------------------
`define OCN_CLK_MHZ     10
`define OCN_MS_US       1000
`define OCN_DEG_MS      8'h05

// --------------------------------------------------------------------------
// Pitch, glissando and routing
// --------------------------------------------------------------------------
`define OCN_PITCH_MIN   8'shdc
`define OCN_PITCH_MAX   8'sh60
`define OCN_GL_ONE      5'h0c
`define OCN_GL_TWO      5'h18
`define OCN_SPLIT_DEF   6'h0c
`define OCN_DEST_A      4'h0
`define OCN_DEST_B      4'h1

// --------------------------------------------------------------------------
// Pedal part modes
// --------------------------------------------------------------------------
`define OCN_PD_NORMAL   2'h0
`define OCN_PD_STOPS    2'h1
`define OCN_PD_COUPLED  2'h2
`define OCN_PD_SELECT   2'h3

`endif

// ==== rtl/ocn_pizz_timer.v ====
`timescale 1ns/1ps
`default_nettype none
module ocn_pizz_timer (
  // Clock and reset
  input  wire       clock,
  input  wire       reset,
  // Trigger and millisecond tick
  input  wire       trig,
  input  wire       tick,
  input  wire [7:0] len,
  // Pulse
  output reg        act_ff
);

  reg [7:0] cnt_ff;

  always @(posedge clock) begin
    if (reset) begin
      act_ff <= 1'b0;
      cnt_ff <= 8'h00;
    end else if (trig) begin
      act_ff <= 1'b1;
      cnt_ff <= len;
    end else if (act_ff && tick) begin
      // A zero length still gives one partial tick of sound.
      if (cnt_ff <= 8'h01) begin
        act_ff <= 1'b0;
      end
      cnt_ff <= cnt_ff - 8'h01;
    end
  end

endmodule
`default_nettype wire

// ==== tb/ocn_note_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module ocn_note_chk #(
  parameter NOTES = 61
) (
  // Clock, reset and pins
  input wire logic             clock,
  input wire logic             reset,
  input wire logic [NOTES-1:0] key_a,
  input wire logic [NOTES-1:0] key_b,
  input wire logic [7:0]       pist_b,
  input wire logic [7:0]       canc_a,
  input wire logic [7:0]       canc_b,
  input wire logic [31:0]      shoe,
  input wire logic [7:0]       stop_on,
  // Controls and configuration
  input wire logic             xfer_on,
  input wire logic             unison_off_a,
  input wire logic             cpl_on,
  input wire logic             gliss_on,
  input wire logic             xfer_cancels,
  input wire logic [7:0]       dup_req,
  input wire logic [1:0]       exp_en,
  // Outputs
  input wire logic [NOTES-1:0] div_a_unc_ff,
  input wire logic [NOTES-1:0] div_a_cpl_ff,
  input wire logic [NOTES-1:0] div_b_cpl_ff,
  input wire logic [NOTES-1:0] midi_on_ff,
  input wire logic [7:0]       pist_a_ff,
  input wire logic [7:0]       canc_a_ff,
  input wire logic             dup_act_ff,
  input wire logic [31:0]      shade_ff
);
  // --------------------------------------------------------------------
  // Sequences
  // --------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  sequence s_direct; (!xfer_on && !gliss_on)[*4]; endsequence
  sequence s_swap;   (xfer_on && !gliss_on)[*4]; endsequence
  // Coupled and plain outputs register on the same edge; the longer hold is margin.
  sequence s_plain;
    (!cpl_on && !xfer_on && !gliss_on && $stable(unison_off_a))[*6];
  endsequence
  sequence s_xhold;
    ($stable(xfer_on) && $stable(xfer_cancels))[*4];
  endsequence
  sequence s_dhold; ($stable(stop_on) && $stable(dup_req))[*4]; endsequence
  AST_UNC: assert property (s_direct |-> div_a_unc_ff == $past(key_a, 3))
    else $error("uncoupled data does not follow its keyboard");
  AST_XFER: assert property (s_swap |-> div_a_unc_ff == $past(key_b, 3))
    else $error("transfer does not swap the keyboards");
  AST_PIST: assert property (xfer_on[*4] |-> pist_a_ff == $past(pist_b, 3))
    else $error("transfer does not swap the pistons");
  AST_CANC: assert property (s_xhold |-> canc_a_ff ==
      (xfer_on && xfer_cancels ? $past(canc_b, 3) : $past(canc_a, 3)))
    else $error("cancel swap does not follow its option");
  AST_UNISON: assert property (s_plain |->
      div_a_cpl_ff == (unison_off_a ? '0 : div_a_unc_ff))
    else $error("unison path has the wrong sense");
  AST_MIDI_ON: assert property (midi_on_ff == div_b_cpl_ff)
    else $error("midi on data differs from the division");
  AST_DUP: assert property (s_dhold |-> dup_act_ff ==
      ($countones(dup_req) >= 2 && (stop_on & dup_req) == dup_req))
    else $error("duplex output wrong");
  AST_SHADE: assert property ((exp_en == 2'h0)[*4] |->
      shade_ff == $past(shoe, 3))
    else $error("shades do not follow their own shoes");
endmodule
bind ocn_note_logic ocn_note_chk #(.NOTES(NOTES)) u_chk (.*);
`default_nettype wire

// ==== tb/ocn_kbd.sv ====
`timescale 1ns/1ps
`default_nettype none
module ocn_kbd (
  // Requested contacts
  input  wire logic [60:0] want_a,
  input  wire logic [60:0] want_b,
  input  wire logic [31:0] want_p,
  input  wire logic [60:0] drop_a,
  // Contacts at the relay
  output wire logic [60:0] key_a,
  output wire logic [60:0] key_b,
  output wire logic [31:0] key_p
);
  // A dropped contact reads open, as a dirty key contact does.
  assign key_a = want_a & ~drop_a;
  assign key_b = want_b;
  assign key_p = want_p;
endmodule
`default_nettype wire

// ==== tb/organ_coupler_note_logic_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
`define OCN_CHK(g, e) begin n_tests++; if ((g) !== (e)) begin \
  error_cnt++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module organ_coupler_note_logic_bench;
  logic clock, reset, xfer_on, unison_off_a, unison_off_b, cpl_on;
  logic melody_on, bass_on, pizz_on, sost_on, gliss_on, intra_on;
  logic xfer_cancels, cpl_src_sel, gliss_two, divide_on;
  logic [60:0] want_a, want_b, drop_a, key_a, key_b;
  logic [31:0] want_p, key_p, shoe;
  logic [7:0] stop_on, pist_a, pist_b, canc_a, canc_b, dup_req, gliss_rate;
  logic [3:0] cpl_dest;
  logic signed [7:0] cpl_pitch, intra_pitch;
  logic [487:0] pizz_len;
  logic [5:0] divide_at, exp_src;
  logic [1:0] pd_low_mode, pd_high_mode, pd_low_sel, pd_high_sel, exp_en;
  logic [15:0] exp_dst;
  logic [60:0] div_a_unc_ff, div_a_cpl_ff, div_b_unc_ff, div_b_cpl_ff;
  logic [60:0] flt_notes_ff, only_on_ff, midi_to_ff, midi_on_ff;
  logic [3:0] flt_dest_ff;
  logic [31:0] ped_stop_ff, ped_cpl_ff, shade_ff;
  logic [7:0] pist_a_ff, pist_b_ff, canc_a_ff, canc_b_ff;
  logic dup_act_ff;
  int error_cnt;
  int n_tests;
  int rn[7] = '{5, 20, 3, 40, 60, 0, 30};
  int rp[7] = '{12, -12, 24, -40, 1, 0, 112};
  int rd[7] = '{2, 0, 1, 15, 3, 2, 2};
  int re[7] = '{17, 8, 27, 4, -1, 0, -1};
  // A millisecond of ten cycles keeps pulse and deglitch times short.
  ocn_note_logic #(.MS_CYC(10)) dut (.*);
  ocn_kbd kbd (.*);
  function automatic [60:0] bit_of(input int n);
    bit_of = n < 0 ? 61'h0 : 61'h1 << n;
  endfunction
  task automatic wait_n(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic complete_run;
    if (error_cnt == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  initial begin
    #1_000_000;
    error_cnt++;
    complete_run();
  end
  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    {xfer_on, unison_off_a, unison_off_b, cpl_on, melody_on, bass_on, pizz_on,
     sost_on, gliss_on, intra_on, xfer_cancels, cpl_src_sel, gliss_two,
     divide_on} = '0;
    {want_a, want_b, want_p, drop_a, exp_en, exp_src} = '0;
    {stop_on, pist_a, pist_b, canc_a, canc_b, dup_req} = '0;
    {pd_low_mode, pd_high_mode, pd_low_sel, pd_high_sel} = '0;
    reset = 1'b1;
    shoe = 32'h5;
    cpl_dest = 4'h0;
    cpl_pitch = 8'sh00;
    intra_pitch = 8'sh0c;
    gliss_rate = 8'h01;
    divide_at = 6'h0c;
    exp_dst = 16'h0006;
    pizz_len = {61{8'h03}};
    pizz_len[200+:8] = 8'h06;
    error_cnt = 0;
    n_tests = 0;
    wait_n(5);
    reset = 1'b0;
    cpl_on = 1'b1;
    for (int i = 0; i < 7; i++) begin
      want_a = bit_of(rn[i]);
      cpl_pitch = 8'(rp[i]);
      cpl_dest = 4'(rd[i]);
      wait_n(8);
      `OCN_CHK(midi_to_ff, bit_of(re[i]))
      `OCN_CHK(flt_notes_ff, rd[i] > 1 ? bit_of(re[i]) : 61'h0)
      `OCN_CHK(div_b_cpl_ff, rd[i] == 1 ? bit_of(re[i]) : 61'h0)
      `OCN_CHK(div_a_cpl_ff, want_a | (rd[i] == 0 ? bit_of(re[i]) : 61'h0))
      `OCN_CHK(flt_dest_ff, cpl_dest)
    end
    cpl_pitch = 8'sh00;
    want_a = bit_of(10) | bit_of(20);
    wait_n(8);
    melody_on = 1'b1;
    wait_n(6);
    `OCN_CHK(flt_notes_ff, bit_of(20))
    want_a |= bit_of(30);
    wait_n(6);
    `OCN_CHK(flt_notes_ff, bit_of(30))
    drop_a = bit_of(30);
    wait_n(10);
    `OCN_CHK(flt_notes_ff, bit_of(30))
    drop_a = '0;
    wait_n(10);
    `OCN_CHK(flt_notes_ff, bit_of(30))
    want_a = bit_of(10) | bit_of(20);
    wait_n(90);
    `OCN_CHK(flt_notes_ff, bit_of(20))
    melody_on = 1'b0;
    want_a = bit_of(20) | bit_of(30);
    wait_n(8);
    bass_on = 1'b1;
    wait_n(6);
    `OCN_CHK(flt_notes_ff, bit_of(20))
    want_a |= bit_of(10);
    wait_n(6);
    `OCN_CHK(flt_notes_ff, bit_of(10))
    want_a = bit_of(20) | bit_of(30);
    wait_n(8);
    `OCN_CHK(flt_notes_ff, 61'h0)
    want_a = bit_of(30);
    wait_n(8);
    want_a = bit_of(20) | bit_of(30);
    wait_n(8);
    `OCN_CHK(flt_notes_ff, bit_of(20))
    bass_on = 1'b0;
    want_a = bit_of(20);
    wait_n(8);
    pizz_on = 1'b1;
    wait_n(8);
    `OCN_CHK(flt_notes_ff, bit_of(20))
    wait_n(52);
    `OCN_CHK(flt_notes_ff, 61'h0)
    want_a |= bit_of(25);
    wait_n(45);
    `OCN_CHK(flt_notes_ff, bit_of(25))
    wait_n(40);
    `OCN_CHK(flt_notes_ff, 61'h0)
    pizz_on = 1'b0;
    want_a = bit_of(20);
    wait_n(8);
    sost_on = 1'b1;
    wait_n(6);
    want_a = '0;
    wait_n(8);
    `OCN_CHK(flt_notes_ff, bit_of(20))
    want_a = bit_of(30);
    wait_n(8);
    want_a = '0;
    wait_n(8);
    `OCN_CHK(flt_notes_ff, bit_of(20))
    sost_on = 1'b0;
    wait_n(8);
    `OCN_CHK(flt_notes_ff, 61'h0)
    cpl_on = 1'b0;
    for (int i = 0; i < 4; i++) begin
      {xfer_cancels, xfer_on} = 2'(i);
      unison_off_a = i[0];
      {unison_off_b, intra_on} = {2{i[1]}};
      divide_on = i != 0;
      {pd_low_mode, pd_low_sel} = {2'(i), 2'(i)};
      want_a = bit_of(i + 1);
      want_b = bit_of(i + 40);
      // Key 13 sits above the split point and stays in normal routing.
      want_p = (32'h5 << i) | 32'h2000;
      {pist_a, pist_b} = {8'(i * 3 + 1), 8'h80 >> i};
      {canc_a, canc_b} = {8'(i + 1), 8'h40 >> i};
      dup_req = i == 0 ? 8'h01 : 8'h03;
      stop_on = i == 1 ? 8'h01 : 8'h03;
      exp_en = 2'(i == 3);
      wait_n(8);
      `OCN_CHK(div_a_unc_ff, i[0] ? want_b : want_a)
      `OCN_CHK(pist_a_ff, i[0] ? pist_b : pist_a)
      `OCN_CHK(canc_a_ff, i == 3 ? canc_b : canc_a)
      `OCN_CHK(dup_act_ff, i > 1)
      `OCN_CHK(shade_ff, i == 3 ? 32'h555 : shoe)
      `OCN_CHK(div_a_cpl_ff, i[0] ? 61'h0 : want_a)
      `OCN_CHK(div_b_unc_ff, i[0] ? want_a : want_b)
      `OCN_CHK(pist_b_ff, i[0] ? pist_a : pist_b)
      `OCN_CHK(canc_b_ff, i == 3 ? canc_a : canc_b)
      `OCN_CHK(only_on_ff, (i[0] ? want_a : want_b) << (i[1] ? 12 : 0))
      `OCN_CHK(midi_on_ff, (i[0] ? want_a : want_b) << (i[1] ? 12 : 0))
      `OCN_CHK(ped_stop_ff, i == 2 ? 32'h2000 : want_p)
      `OCN_CHK(ped_cpl_ff, i == 1 ? 32'h2000 : want_p)
    end
    {xfer_on, xfer_cancels} = 2'h0;
    reset = 1'b1;
    want_a = bit_of(7);
    wait_n(3);
    `OCN_CHK(div_a_unc_ff, 61'h0)
    reset = 1'b0;
    wait_n(8);
    `OCN_CHK(div_a_unc_ff, bit_of(7))
    want_a = bit_of(5);
    gliss_two = 1'b1;
    gliss_on = 1'b1;
    wait_n(500);
    `OCN_CHK(div_a_unc_ff, bit_of(29))
    complete_run();
  end
endmodule
`default_nettype wire
